//--- rtl/mit_pkg.sv
// Summary of operation
// (RQ1) The counter is an eight-bit up counter of the selected basic clock, compared with the modulo value.
// (RQ2) Control bits 1 and 0 choose the basic clock of the counter.
// (RQ3) Four basic clock rates exist: 100 kHz, 10 kHz, 2 kHz and 1 kHz.
// (RQ4) Control bit 3 gates the basic clock, so counting runs only while it is set.
// (RQ5) Writing a one to control bit 2 clears the counter.
// (RQ6) A timer interrupt request is raised when the count becomes equal to the modulo value.
// (RQ7) On that match the counter returns to zero by itself, so matches repeat.
// (RQ8) Software reads the current count through the transfer buffer.
// (RQ9) Software loads the modulo value from the transfer buffer.
// (RQ10) Select code 00 gives 100 kHz, 01 gives 10 kHz, 10 gives 2 kHz and 11 gives 1 kHz.
// (RQ11) Control bit 2 always reads as zero and acts only when written.
// (RQ12) While counting is stopped the count holds, and resumes from there when restarted.
package mit_pkg;

    localparam int unsigned MCLK_HZ   = 25_000_000;
    localparam int unsigned RATE0_HZ  = 100_000;
    localparam int unsigned RATE1_HZ  = 10_000;
    localparam int unsigned RATE2_HZ  = 2_000;
    localparam int unsigned RATE3_HZ  = 1_000;
    localparam int unsigned DIV0      = MCLK_HZ / RATE0_HZ;
    localparam int unsigned DIV1      = MCLK_HZ / RATE1_HZ;
    localparam int unsigned DIV2      = MCLK_HZ / RATE2_HZ;
    localparam int unsigned DIV3      = MCLK_HZ / RATE3_HZ;
    localparam int unsigned DIV_W     = 15;

    localparam logic [5:0] ADDR_MATCH = 6'h1c;
    localparam logic [5:0] ADDR_COUNT = 6'h1d;
    localparam logic [5:0] ADDR_CTL   = 6'h2a;

    localparam int unsigned CTL_SEL_LO = 0;
    localparam int unsigned CTL_SEL_HI = 1;
    localparam int unsigned CTL_CLEAR  = 2;
    localparam int unsigned CTL_RUN    = 3;

    localparam logic [3:0] CTL_RESET   = 4'h0;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] MATCH_RESET = 8'hff;

    typedef enum logic [1:0] {
        SEL_100K = 2'h0,
        SEL_10K  = 2'h1,
        SEL_2K   = 2'h2,
        SEL_1K   = 2'h3
    } mit_sel_t;

endpackage : mit_pkg

//--- rtl/mit_tick_if.sv
`timescale 1ns/1ps
interface mit_tick_if;
    mit_pkg::mit_sel_t clkSel;
    logic              tick;
    modport src  (input clkSel, output tick);
    modport sink (output clkSel, input tick);
endinterface : mit_tick_if

//--- rtl/mit_prescaler.sv
`timescale 1ns/1ps
module mit_prescaler #(
    parameter int unsigned DIV_2K = mit_pkg::DIV2,
    parameter int unsigned DIV_1K = mit_pkg::DIV3
) (
    input  wire logic  mclk,
    input  wire logic  rst,
    input  wire logic  clkEn,
    mit_tick_if.src    tk
);
    logic [mit_pkg::DIV_W-1:0] div_r;
    logic [mit_pkg::DIV_W-1:0] limit;

    // Basic clock period per select code
    // (RQ10) select decode
    always_comb begin
        case (tk.clkSel)
            mit_pkg::SEL_100K: limit = mit_pkg::DIV_W'(mit_pkg::DIV0);
            mit_pkg::SEL_10K:  limit = mit_pkg::DIV_W'(mit_pkg::DIV1);
            mit_pkg::SEL_2K:   limit = mit_pkg::DIV_W'(DIV_2K);
            mit_pkg::SEL_1K:   limit = mit_pkg::DIV_W'(DIV_1K);
            default:           limit = mit_pkg::DIV_W'(mit_pkg::DIV0);
        endcase
    end

    // (RQ3) four rate divider
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_r   <= '0;
            tk.tick <= 1'b0;
        end else if (clkEn) begin
            if (div_r >= limit - 1'b1) begin
                div_r   <= '0;
                tk.tick <= 1'b1;
            end else begin
                div_r   <= div_r + 1'b1;
                tk.tick <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_div_gap;
        clkEn && div_r == '0 && $stable(tk.clkSel) && tk.clkSel == mit_pkg::SEL_100K
            |=> !tk.tick;
    endproperty
    a_div_gap: assert property (p_div_gap) else $error("tick too soon"); // RQ3

    property p_div_tick;
        clkEn && div_r == limit - 1'b1 |=> tk.tick && div_r == '0;
    endproperty
    a_div_tick: assert property (p_div_tick) else $error("tick missed at limit"); // RQ10

endmodule : mit_prescaler

//--- rtl/modulo_interval_timer.sv
`timescale 1ns/1ps
module modulo_interval_timer #(
    parameter int unsigned DIV_2K = mit_pkg::DIV2,
    parameter int unsigned DIV_1K = mit_pkg::DIV3
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       clkEn,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [5:0] regAddr,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    output logic            timerIrq
);
    ////////////////////////////////////////////////////////////////////////////
    logic [3:0] ctl_r;
    logic [7:0] countValue_r;
    logic [7:0] countValue_nxt;
    logic [7:0] matchValue_r;
    logic       ctlWr;
    logic       matchPut;
    logic       clearReq;
    logic       countRun;
    logic       advance;
    logic [7:0] countInc;

    mit_tick_if tk ();

    assign ctlWr    = regWrite && regAddr == mit_pkg::ADDR_CTL;
    assign matchPut = regWrite && regAddr == mit_pkg::ADDR_MATCH;
    assign clearReq = ctlWr && regWdata[mit_pkg::CTL_CLEAR];
    assign countRun = ctl_r[mit_pkg::CTL_RUN];
    // (RQ4) run gates basic clock
    assign advance  = tk.tick && countRun;
    assign countInc = countValue_r + 8'h01;
    // (RQ2) select from bits 1 and 0
    assign tk.clkSel = mit_pkg::mit_sel_t'(ctl_r[mit_pkg::CTL_SEL_HI:mit_pkg::CTL_SEL_LO]);

    mit_prescaler #(
        .DIV_2K (DIV_2K),
        .DIV_1K (DIV_1K)
    ) u_pre (
        .mclk  (mclk),
        .rst   (rst),
        .clkEn (clkEn),
        .tk    (tk)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Control nibble; clear bit is not stored
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctl_r <= mit_pkg::CTL_RESET;
        end else if (clkEn && ctlWr) begin
            ctl_r <= {regWdata[mit_pkg::CTL_RUN], 1'b0,
                      regWdata[mit_pkg::CTL_SEL_HI:mit_pkg::CTL_SEL_LO]};
        end
    end

    // (RQ9) modulo load by put
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            matchValue_r <= mit_pkg::MATCH_RESET;
        end else if (clkEn && matchPut) begin
            matchValue_r <= regWdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        countValue_nxt = countValue_r;
        // (RQ5) clear on write
        if (clearReq) begin
            countValue_nxt = mit_pkg::COUNT_RESET;
        // (RQ7) auto return to zero
        end else if (advance && countInc == matchValue_r) begin
            countValue_nxt = mit_pkg::COUNT_RESET;
        // (RQ1) eight-bit up count
        end else if (advance) begin
            countValue_nxt = countInc;
        end
    end

    // (RQ12) hold while stopped
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            countValue_r <= mit_pkg::COUNT_RESET;
        end else if (clkEn) begin
            countValue_r <= countValue_nxt;
        end
    end

    // (RQ6) request on match
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            timerIrq <= 1'b0;
        end else if (clkEn) begin
            timerIrq <= advance && !clearReq && countInc == matchValue_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port; unmapped reads return zero
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            regRdata <= 8'h00;
        end else if (clkEn && regRead) begin
            case (regAddr)
                // (RQ11) clear bit reads zero
                mit_pkg::ADDR_CTL:   regRdata <= {4'h0, ctl_r};
                // (RQ8) count read by get
                mit_pkg::ADDR_COUNT: regRdata <= countValue_r;
                mit_pkg::ADDR_MATCH: regRdata <= matchValue_r;
                default:             regRdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_clear;
        clkEn && clearReq |=> countValue_r == 8'h00 && !timerIrq;
    endproperty
    a_clear: assert property (p_clear) else $error("counter not cleared"); // RQ5

    property p_hold;
        clkEn && !countRun && !clearReq |=> countValue_r == $past(countValue_r);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while stopped"); // RQ12

    property p_gate;
        !tk.tick && !clearReq |=> $stable(countValue_r);
    endproperty
    a_gate: assert property (p_gate) else $error("count moved without tick"); // RQ4

    property p_match;
        clkEn && advance && !clearReq && countInc == matchValue_r
            |=> timerIrq && countValue_r == 8'h00;
    endproperty
    a_match: assert property (p_match) else $error("match not handled"); // RQ7

    property p_irq_cause;
        $past(clkEn) && timerIrq |-> $past(advance) && $past(countInc) == $past(matchValue_r);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("request without match"); // RQ6

    property p_inc;
        clkEn && advance && !clearReq && countInc != matchValue_r
            |=> countValue_r == $past(countValue_r) + 8'h01;
    endproperty
    a_inc: assert property (p_inc) else $error("count did not advance"); // RQ1

    property p_ctl_read;
        clkEn && regRead && regAddr == mit_pkg::ADDR_CTL
            |=> regRdata[mit_pkg::CTL_CLEAR] == 1'b0 && regRdata[3] == $past(countRun);
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("bad control readback"); // RQ11

    property p_get;
        clkEn && regRead && regAddr == mit_pkg::ADDR_COUNT |=> regRdata == $past(countValue_r);
    endproperty
    a_get: assert property (p_get) else $error("count read mismatch"); // RQ8

    property p_put;
        clkEn && matchPut |=> matchValue_r == $past(regWdata);
    endproperty
    a_put: assert property (p_put) else $error("modulo not loaded"); // RQ9

    property p_sel;
        clkEn && ctlWr |=> tk.clkSel == mit_pkg::mit_sel_t'($past(regWdata[1:0]));
    endproperty
    a_sel: assert property (p_sel) else $error("select not applied"); // RQ2

    property p_irq_pulse;
        clkEn && timerIrq |=> !timerIrq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("request too long"); // RQ6

    property p_match_keep;
        !(clkEn && matchPut) |=> $stable(matchValue_r);
    endproperty
    a_match_keep: assert property (p_match_keep) else $error("modulo changed unasked"); // RQ9

    property p_ctl_keep;
        !(clkEn && ctlWr) |=> $stable(ctl_r);
    endproperty
    a_ctl_keep: assert property (p_ctl_keep) else $error("control changed unasked"); // RQ2

    property p_rdata_keep;
        !(clkEn && regRead) |=> $stable(regRdata);
    endproperty
    a_rdata_keep: assert property (p_rdata_keep) else $error("read data moved"); // RQ8

    property p_clear_unstored;
        ctl_r[mit_pkg::CTL_CLEAR] == 1'b0;
    endproperty
    a_clear_unstored: assert property (p_clear_unstored) else $error("clear bit stored"); // RQ11

    property p_freeze;
        !clkEn |=> $stable(countValue_r) && $stable(timerIrq);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled"); // RQ4

    property p_stop_quiet;
        clkEn && !countRun && !clearReq |=> !timerIrq;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("request while stopped"); // RQ4

    property p_cov_irq;
        timerIrq;
    endproperty
    c_cov_irq: cover property (p_cov_irq);

    property p_cov_clear_run;
        countRun && clearReq;
    endproperty
    c_cov_clear_run: cover property (p_cov_clear_run);

    property p_cov_resume;
        !countRun ##1 countRun ##[1:300] advance;
    endproperty
    c_cov_resume: cover property (p_cov_resume);

    property p_cov_stop;
        countRun ##1 !countRun;
    endproperty
    c_cov_stop: cover property (p_cov_stop);

endmodule : modulo_interval_timer

//--- bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin nErrors++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top;
    logic       mclk     = 1'b0;
    logic       rst      = 1'b1;
    logic       clkEn    = 1'b1;
    logic       regWrite = 1'b0;
    logic       regRead  = 1'b0;
    logic [5:0] regAddr  = 6'h00;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] regRdata;
    logic       timerIrq;
    int         nErrors    = 0;
    int         checksDone = 0;
    logic [7:0] d;
    logic [7:0] c0;
    logic [7:0] c1;
    int         n;
    int         divs [4] = '{250, 2500, 20, 40};

    always #20 mclk = ~mclk;

    modulo_interval_timer #(.DIV_2K(20), .DIV_1K(40)) i_dut (
        .mclk     (mclk),
        .rst      (rst),
        .clkEn    (clkEn),
        .regWrite (regWrite),
        .regRead  (regRead),
        .regAddr  (regAddr),
        .regWdata (regWdata),
        .regRdata (regRdata),
        .timerIrq (timerIrq)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic stopTest;
        if (nErrors == 0 && checksDone > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stopTest

    task automatic wr(input logic [5:0] a, input logic [7:0] v);
        @(posedge mclk);
        regWrite <= 1'b1;
        regAddr  <= a;
        regWdata <= v;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [7:0] v);
        @(posedge mclk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        v = regRdata;
    endtask : rd

    // Bounded wait for the next request pulse
    task automatic waitIrq(output int k);
        k = 0;
        do begin
            @(negedge mclk);
            k++;
        end while (timerIrq !== 1'b1 && k < 40000);
        if (k >= 40000) begin
            nErrors++;
            $display("MISMATCH irqWait exp 1 got timeout");
        end
    endtask : waitIrq

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        rd(6'h2a, d); `CHK("ctlReset", 8'h00, d)
        rd(6'h1d, d); `CHK("countReset", 8'h00, d)
        rd(6'h1c, d); `CHK("matchReset", 8'hff, d)
        rd(6'h3f, d); `CHK("unmapped", 8'h00, d)
        wr(6'h1c, 8'h5a);
        rd(6'h1c, d); `CHK("matchLoad", 8'h5a, d)
        // Write strobe ignored while disabled
        @(posedge mclk);
        clkEn <= 1'b0;
        wr(6'h1c, 8'h44);
        clkEn <= 1'b1;
        rd(6'h1c, d); `CHK("matchGated", 8'h5a, d)
        wr(6'h1c, 8'h03);
        for (int s = 0; s < 4; s++) begin
            wr(6'h2a, 8'h0c | 8'(s));
            rd(6'h2a, d); `CHK("ctlRead", 8'h08 | 8'(s), d)
            waitIrq(n);
            @(negedge mclk); `CHK("irqPulse", 1'b0, timerIrq)
            waitIrq(n);
            `CHK("period", 3 * divs[s], n + 1)
        end
        wr(6'h1c, 8'hff);
        wr(6'h2a, 8'h0e);
        repeat (100) @(posedge mclk);
        wr(6'h2a, 8'h02);
        rd(6'h1d, c0); `CHK("runCount", 1'b1, c0 >= 8'h04 && c0 <= 8'h07)
        repeat (100) @(posedge mclk);
        rd(6'h1d, c1); `CHK("holdCount", c0, c1)
        wr(6'h2a, 8'h0a);
        repeat (200) @(posedge mclk);
        wr(6'h2a, 8'h02);
        rd(6'h1d, c1); `CHK("resume", 1'b1, (c1 - c0) >= 8'h09 && (c1 - c0) <= 8'h0c)
        wr(6'h2a, 8'h06);
        rd(6'h1d, d); `CHK("clearCount", 8'h00, d)
        rd(6'h2a, d); `CHK("clearReads0", 8'h02, d)
        wr(6'h1d, 8'h33);
        rd(6'h1d, d); `CHK("countRo", 8'h00, d)
        // auto return to zero just after match
        wr(6'h1c, 8'h02);
        wr(6'h2a, 8'h0a);
        waitIrq(n);
        wr(6'h2a, 8'h02);
        rd(6'h1d, d); `CHK("wrapZero", 8'h00, d)
        stopTest();
    end

    initial begin
        repeat (60000) @(posedge mclk);
        nErrors++;
        $display("MISMATCH watchdog exp finish got timeout");
        stopTest();
    end
endmodule : tb_top
